// *** design/ccr_pkg.sv ***
// constants and types for the calendar clock alarm register block
package ccr_pkg;
  localparam logic [7:0] OFS_CAL_NOW = 8'h00;
  localparam logic [7:0] OFS_CAL_ALARM = 8'h04;
  localparam logic [7:0] OFS_CAL_PRESET = 8'h08;
  localparam logic [7:0] OFS_YEAR_NOW = 8'h0c;
  localparam logic [7:0] OFS_YEAR_ALARM = 8'h10;
  localparam logic [7:0] OFS_YEAR_PRESET = 8'h14;
  localparam logic [7:0] OFS_DIV_TRIM = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_IRQ_RAW = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASKED = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_TIMER_COUNT = 8'h2c;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h30;
  localparam logic [7:0] OFS_RELOAD_A = 8'h34;
  localparam logic [7:0] OFS_RELOAD_B = 8'h38;
  localparam logic [7:0] OFS_PAT_W0 = 8'h3c;
  localparam logic [7:0] OFS_PAT_W1 = 8'h40;
  localparam logic [7:0] OFS_PAT_W2 = 8'h44;
  localparam logic [7:0] OFS_PAT_W3 = 8'h48;
  localparam logic [7:0] OFS_TIMER_IRQS = 8'h4c;

  localparam logic [31:0] CAL_RESET = 32'h02120000;
  localparam logic [13:0] YEAR_RESET = 14'h2000;
  localparam logic [13:0] YEAR_LAST = 14'h3999;
  localparam logic [14:0] DIV_RESET = 15'h7fff;
  localparam logic [31:0] TIMER_COUNT_RESET = 32'hffffffff;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] MIN_LAST = 6'h3b;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [2:0] WDAY_FIRST = 3'h1;
  localparam logic [2:0] WDAY_LAST = 3'h7;
  localparam logic [2:0] WDAY_IGNORE = 3'h0;
  localparam logic [4:0] MDAY_FIRST = 5'h01;
  localparam logic [4:0] MDAY_IGNORE = 5'h00;
  localparam logic [4:0] MDAY_28 = 5'h1c;
  localparam logic [4:0] MDAY_29 = 5'h1d;
  localparam logic [4:0] MDAY_30 = 5'h1e;
  localparam logic [4:0] MDAY_31 = 5'h1f;
  localparam logic [3:0] MONTH_IGNORE = 4'h0;
  localparam logic [3:0] MONTH_JAN = 4'h1;
  localparam logic [3:0] MONTH_FEB = 4'h2;
  localparam logic [3:0] MONTH_APR = 4'h4;
  localparam logic [3:0] MONTH_JUN = 4'h6;
  localparam logic [3:0] MONTH_SEP = 4'h9;
  localparam logic [3:0] MONTH_NOV = 4'hb;
  localparam logic [3:0] MONTH_DEC = 4'hc;
  localparam logic [3:0] BCD_NINE = 4'h9;

  localparam int IRQ_CAL = 0;
  localparam int IRQ_TIMER = 1;
  localparam int IRQ_BITS = 2;
  localparam int PAT_WORDS = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic [2:0] pad;
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
  } ccr_cal_type;
endpackage : ccr_pkg

// *** design/ccr_top.sv ***
// calendar clock with alarm comparator and timer register map on an ahb-lite slave
//
// Behaviour
// - calendar word: sec 5:0, min 11:6, hour 16:12, wday 19:17, mday 24:20, month 28:25
// - calendar now at 0x00 is read-only, resets to 0x02120000
// - seconds and minutes count 0..0x3b, hours 0..0x17
// - weekday codes Sunday 1 through Saturday 7, zero never used
// - day of month limit 28, 29, 30 or 31 by month and leap year
// - month codes January 1 through December 12
// - alarm seconds 0x3c..0x3f never match
// - alarm minutes 0x3c..0x3f never match, else compare with minutes
// - alarm hours 0x18..0x1f never match, else compare with hours
// - alarm weekday zero ignores weekday, else must equal
// - alarm day of month zero ignores it, else must equal
// - alarm month zero ignores, 1..12 must equal, 13..15 never match
// - alarm match at 0x04 is read-write, resets to zero
// - year now at 0x0c read-only, year alarm at 0x10 read-write, both reset 0x2000
// - calendar preset at 0x08 and year preset at 0x14, read-write, reset zero
// - divider trim control at 0x18 read-write, resets to 0x7fff
// - irq mask 0x1c, raw 0x20, masked 0x24, clear 0x28, all reset zero
// - timer count at 0x2c read-only, resets to all ones
// - timer reloads at 0x34, 0x38 read-write reset zero; timer control at 0x30
// - 128-bit reload pattern in 0x3c..0x48, lowest word holds bits 31:0
// - timer interrupt count at 0x4c read-only, resets zero
// - seconds advance once per one-hertz tick
// - preset values copied into the calendar on the next tick after a write
// - after each increment compare calendar and year with alarms, raise alarm on match
// - tick comes from slow clock divided by divider value plus one
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module ccr_top
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic slow_clock,
  output logic one_hz_tick,
  output logic calendar_alarm_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic is_leap(input logic [13:0] y);
    // century years are not special; the year only spans four bcd digits
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic logic [4:0] month_len(input logic [3:0] m, input logic leap);
    case (m)
      MONTH_FEB: month_len = leap ? MDAY_29 : MDAY_28;
      MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: month_len = MDAY_30;
      default: month_len = MDAY_31;
    endcase
  endfunction : month_len

  function automatic logic [13:0] year_inc(input logic [13:0] y);
    logic [15:0] d;
    logic c;
    d = {2'h0, y};
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (d[i*4 +: 4] == BCD_NINE) begin
          d[i*4 +: 4] = 4'h0;
        end else begin
          d[i*4 +: 4] = d[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    year_inc = (y == YEAR_LAST) ? 14'h0000 : d[13:0];
  endfunction : year_inc

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: reads take one wait state so a write just before is seen
  logic [7:0] dp_addr;
  logic dp_write;
  logic dp_read;
  logic [31:0] rdata;
  logic accept;

  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_addr <= 8'h00;
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= WORD_ZERO;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      dp_write <= accept && hwrite;
      if (accept) begin
        dp_addr <= haddr[7:0];
      end
      if (dp_read) begin
        hrdata <= rdata;
        hreadyout <= 1'b1;
        dp_read <= 1'b0;
      end else begin
        dp_read <= accept && !hwrite;
        hreadyout <= !(accept && !hwrite);
      end
    end
  end

  logic wr_en;
  assign wr_en = dp_write;

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  ccr_cal_type cal;
  ccr_cal_type alarm;
  ccr_cal_type preset;
  logic [13:0] year;
  logic [13:0] year_alarm;
  logic [13:0] year_preset;
  logic [14:0] tick_divider;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] irq_raw;
  logic [31:0] timer_control;
  logic [31:0] timer_reload_a;
  logic [31:0] timer_reload_b;
  logic [31:0] pattern [PAT_WORDS];
  logic load_pend;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm <= WORD_ZERO;
      preset <= WORD_ZERO;
      year_alarm <= YEAR_RESET;
      year_preset <= 14'h0000;
      tick_divider <= DIV_RESET;
      irq_mask <= '0;
      timer_control <= WORD_ZERO;
      timer_reload_a <= WORD_ZERO;
      timer_reload_b <= WORD_ZERO;
    end else if (wr_en) begin
      case (dp_addr)
        OFS_CAL_ALARM: alarm <= {3'h0, hwdata[28:0]};
        OFS_CAL_PRESET: preset <= {3'h0, hwdata[28:0]};
        OFS_YEAR_ALARM: year_alarm <= hwdata[13:0];
        OFS_YEAR_PRESET: year_preset <= hwdata[13:0];
        OFS_DIV_TRIM: tick_divider <= hwdata[14:0];
        OFS_IRQ_MASK: irq_mask <= hwdata[IRQ_BITS-1:0];
        OFS_TIMER_CTRL: timer_control <= hwdata;
        OFS_RELOAD_A: timer_reload_a <= hwdata;
        OFS_RELOAD_B: timer_reload_b <= hwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PAT_WORDS; i++) begin
        pattern[i] <= WORD_ZERO;
      end
    end else if (wr_en) begin
      case (dp_addr)
        OFS_PAT_W0: pattern[0] <= hwdata;
        OFS_PAT_W1: pattern[1] <= hwdata;
        OFS_PAT_W2: pattern[2] <= hwdata;
        OFS_PAT_W3: pattern[3] <= hwdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (dp_addr)
      OFS_CAL_NOW: rdata = cal;
      OFS_CAL_ALARM: rdata = alarm;
      OFS_CAL_PRESET: rdata = preset;
      OFS_YEAR_NOW: rdata = {18'h00000, year};
      OFS_YEAR_ALARM: rdata = {18'h00000, year_alarm};
      OFS_YEAR_PRESET: rdata = {18'h00000, year_preset};
      OFS_DIV_TRIM: rdata = {17'h00000, tick_divider};
      OFS_IRQ_MASK: rdata = {30'h00000000, irq_mask};
      OFS_IRQ_RAW: rdata = {30'h00000000, irq_raw};
      OFS_IRQ_MASKED: rdata = {30'h00000000, irq_raw & irq_mask};
      OFS_TIMER_COUNT: rdata = TIMER_COUNT_RESET;
      OFS_TIMER_CTRL: rdata = timer_control;
      OFS_RELOAD_A: rdata = timer_reload_a;
      OFS_RELOAD_B: rdata = timer_reload_b;
      OFS_PAT_W0: rdata = pattern[0];
      OFS_PAT_W1: rdata = pattern[1];
      OFS_PAT_W2: rdata = pattern[2];
      OFS_PAT_W3: rdata = pattern[3];
      OFS_TIMER_IRQS: rdata = WORD_ZERO;
      default: rdata = WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one hertz tick from the slow clock; divider zero stops the calendar
  logic slow_prev;
  logic [14:0] div_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // high at reset so a slow clock already high is not taken for a rising edge
      slow_prev <= 1'b1;
      div_cnt <= 15'h0000;
      one_hz_tick <= 1'b0;
    end else begin
      slow_prev <= slow_clock;
      one_hz_tick <= 1'b0;
      if (slow_clock && !slow_prev && (tick_divider != 15'h0000)) begin
        if (div_cnt >= tick_divider) begin
          div_cnt <= 15'h0000;
          one_hz_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 15'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calendar counters
  ccr_cal_type next_cal;
  logic [13:0] next_year;

  always_comb begin
    next_cal = cal;
    next_year = year;
    if (cal.seconds < SEC_LAST) begin
      next_cal.seconds = cal.seconds + 6'h01;
    end else begin
      next_cal.seconds = 6'h00;
      if (cal.minutes < MIN_LAST) begin
        next_cal.minutes = cal.minutes + 6'h01;
      end else begin
        next_cal.minutes = 6'h00;
        if (cal.hours < HOUR_LAST) begin
          next_cal.hours = cal.hours + 5'h01;
        end else begin
          next_cal.hours = 5'h00;
          next_cal.wday = (cal.wday == WDAY_LAST) ? WDAY_FIRST : cal.wday + 3'h1;
          if (cal.mday < month_len(cal.month, is_leap(year))) begin
            next_cal.mday = cal.mday + 5'h01;
          end else begin
            next_cal.mday = MDAY_FIRST;
            if (cal.month < MONTH_DEC) begin
              next_cal.month = cal.month + 4'h1;
            end else begin
              next_cal.month = MONTH_JAN;
              next_year = year_inc(year);
            end
          end
        end
      end
    end
  end

  logic wr_preset;
  assign wr_preset = wr_en && ((dp_addr == OFS_CAL_PRESET) || (dp_addr == OFS_YEAR_PRESET));

  // a write landing on the tick edge stays pending so the new value is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= (load_pend && !one_hz_tick) || wr_preset;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal <= CAL_RESET;
      year <= YEAR_RESET;
    end else if (one_hz_tick) begin
      if (load_pend) begin
        cal <= preset;
        year <= year_preset;
      end else begin
        cal <= next_cal;
        year <= next_year;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm comparator, checked the cycle after each calendar update
  logic cmp_go;
  logic match_now;

  always_comb begin
    match_now = (alarm.seconds <= SEC_LAST) && (alarm.seconds == cal.seconds)
      && (alarm.minutes <= MIN_LAST) && (alarm.minutes == cal.minutes)
      && (alarm.hours <= HOUR_LAST) && (alarm.hours == cal.hours)
      && ((alarm.wday == WDAY_IGNORE) || (alarm.wday == cal.wday))
      && ((alarm.mday == MDAY_IGNORE) || (alarm.mday == cal.mday))
      && ((alarm.month == MONTH_IGNORE)
          || ((alarm.month <= MONTH_DEC) && (alarm.month == cal.month)))
      && ((year_alarm == 14'h0000) || (year_alarm == year));
  end

  logic [IRQ_BITS-1:0] irq_clr;
  logic [IRQ_BITS-1:0] irq_set;
  assign irq_clr = (wr_en && (dp_addr == OFS_IRQ_CLEAR)) ? hwdata[IRQ_BITS-1:0] : '0;
  assign irq_set = {1'b0, cmp_go && match_now}; // timer event not driven here

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_go <= 1'b0;
      irq_raw <= '0;
      calendar_alarm_irq <= 1'b0;
    end else begin
      cmp_go <= one_hz_tick;
      irq_raw <= (irq_raw & ~irq_clr) | irq_set;
      calendar_alarm_irq <= irq_raw[IRQ_CAL] && irq_mask[IRQ_CAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESERVED_ZERO: assert property (cal.pad == 3'h0)
    else $error("reserved calendar bits not zero");
  AST_TIME_RANGE: assert property (one_hz_tick && !load_pend
    && cal.seconds == SEC_LAST |=> cal.seconds == 6'h00)
    else $error("seconds did not wrap after last value");
  AST_TICK_ADVANCE: assert property (one_hz_tick && !load_pend && cal.seconds < SEC_LAST
    |=> cal.seconds == $past(cal.seconds) + 6'h01)
    else $error("seconds did not advance on tick");
  AST_LOAD_COPY: assert property (one_hz_tick && load_pend
    |=> cal == $past(preset) && year == $past(year_preset))
    else $error("preset not copied on tick");
  AST_SEC_INVALID: assert property (alarm.seconds > SEC_LAST |-> !match_now)
    else $error("invalid seconds alarm matched");
  AST_MIN_INVALID: assert property (alarm.minutes > MIN_LAST |-> !match_now)
    else $error("invalid minutes alarm matched");
  AST_HOUR_INVALID: assert property (alarm.hours > HOUR_LAST |-> !match_now)
    else $error("invalid hours alarm matched");
  AST_MONTH_INVALID: assert property (alarm.month > MONTH_DEC |-> !match_now)
    else $error("invalid month alarm matched");
  AST_ALARM_RAISE: assert property (one_hz_tick ##1 match_now
    |=> irq_raw[IRQ_CAL] ##1 (calendar_alarm_irq == irq_mask[IRQ_CAL] || irq_clr[IRQ_CAL]))
    else $error("alarm not raised after match");
  AST_WDAY_WRAP: assert property (one_hz_tick && !load_pend && cal.wday == WDAY_LAST
    && next_cal.hours == 5'h00 && cal.hours == HOUR_LAST |=> cal.wday == WDAY_FIRST)
    else $error("weekday did not wrap to first");
  AST_READ_WAIT: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_MASKED_OUT: assert property (!irq_mask[IRQ_CAL] |=> !calendar_alarm_irq)
    else $error("masked alarm reached the output");
  AST_SET_WINS: assert property (cmp_go && match_now |=> irq_raw[IRQ_CAL])
    else $error("alarm match did not set raw status");

endmodule : ccr_top
`default_nettype wire

// *** design/dummy_unused_never.sv ***
// holds no logic; the whole calendar clock alarm register block lives in ccr_top

// *** tb/tb.sv ***
// self-checking bench for the calendar clock alarm register block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic slow_clock = 1'b0;
  logic [2:0] slow_cnt = 3'h0;
  logic one_hz_tick;
  logic calendar_alarm_irq;
  logic rd_phase = 1'b0;
  logic [39:0] exp_q [$];
  logic [39:0] note;
  logic [31:0] seed = 32'h26;
  int fail_count = 0;
  int cmp_count = 0;
  int n;
  //////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  // slow clock period of 8 clk keeps a tick short enough to run many of them
  always @(posedge clk) begin
    slow_cnt <= slow_cnt + 3'h1;
    slow_clock <= slow_cnt[2];
  end
  ccr_top u_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .slow_clock(slow_clock), .one_hz_tick(one_hz_tick),
    .calendar_alarm_irq(calendar_alarm_irq)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [31:0] cal(input logic [5:0] s, input logic [5:0] m,
      input logic [4:0] h, input logic [2:0] w, input logic [4:0] d, input logic [3:0] mo);
    return {3'h0, mo, d, w, h, m, s};
  endfunction : cal
  // read data is compared by the monitor below, never inside the bus task
  always @(posedge clk) begin
    if (rd_phase && hreadyout === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check(hrdata, note[31:0], $sformatf("read %h", note[39:32]));
      check({31'h0, hresp}, 32'h0, "hresp");
    end
    if (hreadyout === 1'b1) begin
      rd_phase <= hsel && htrans[1] && !hwrite;
    end
  end
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic wait_tick;
    do @(posedge clk); while (one_hz_tick !== 1'b1);
  endtask : wait_tick
  //////////////////////////////////////////////////////////////////////////////
  // preset is written just after a tick so it never collides with one
  task automatic roll(input logic [31:0] p, input logic [13:0] py, input logic [31:0] e,
      input logic [13:0] ey);
    wait_tick();
    wr(OFS_CAL_PRESET, p);
    wr(OFS_YEAR_PRESET, {18'h0, py});
    wait_tick();
    repeat (2) @(posedge clk);
    rd(OFS_CAL_NOW, p);
    rd(OFS_YEAR_NOW, {18'h0, py});
    wait_tick();
    repeat (2) @(posedge clk);
    rd(OFS_CAL_NOW, e);
    rd(OFS_YEAR_NOW, {18'h0, ey});
  endtask : roll
  // an invalid field in the preset lets a missing invalid filter match at the load tick
  task automatic alarm_case(input logic [31:0] a, input logic [13:0] ya, input logic m,
      input logic e, input logic [31:0] p);
    wait_tick();
    wr(OFS_IRQ_CLEAR, 32'h3);
    wr(OFS_CAL_ALARM, a);
    wr(OFS_YEAR_ALARM, {18'h0, ya});
    wr(OFS_IRQ_MASK, {31'h0, m});
    wr(OFS_CAL_PRESET, p);
    wr(OFS_YEAR_PRESET, 32'h2001);
    wait_tick();
    wait_tick();
    repeat (3) @(posedge clk);
    check({31'h0, calendar_alarm_irq}, {31'h0, e & m}, "alarm irq");
    rd(OFS_IRQ_RAW, {31'h0, e});
    rd(OFS_IRQ_MASKED, {31'h0, e & m});
  endtask : alarm_case
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    logic [31:0] rst_val [20];
    logic [7:0] rw_a [10];
    logic [31:0] rw_m [10];
    logic [31:0] base;
    rst_val = '{32'h02120000, 32'h0, 32'h0, 32'h2000, 32'h2000, 32'h0, 32'h7fff, 32'h0,
                32'h0, 32'h0, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                32'h0, 32'h0, 32'h0};
    rw_a = '{OFS_CAL_ALARM, OFS_CAL_PRESET, OFS_YEAR_ALARM, OFS_YEAR_PRESET, OFS_RELOAD_A,
             OFS_RELOAD_B, OFS_PAT_W0, OFS_PAT_W1, OFS_PAT_W2, OFS_PAT_W3};
    rw_m = '{32'h1fffffff, 32'h1fffffff, 32'h3fff, 32'h3fff, 32'hffffffff, 32'hffffffff,
             32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
    base = cal(6'h0, 6'h0, 5'h0, 3'h1, 5'h01, 4'h3);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      rd(8'(i * 4), rst_val[i]);
    end
    rd(8'h50, 32'h0);
    $display("test reset values done");
    // random words; reserved high bits must read back as zero
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      wr(rw_a[i], seed);
      rd(rw_a[i], seed & rw_m[i]);
    end
    foreach (rst_val[i]) begin
      if (i == 0 || i == 3 || i == 11) begin
        seed = xs(seed);
        wr(8'(i * 4), seed);
        rd(8'(i * 4), rst_val[i]);
      end
    end
    rd(OFS_IRQ_CLEAR, 32'h0);
    $display("test register access done");
    wr(OFS_DIV_TRIM, 32'h2);
    rd(OFS_DIV_TRIM, 32'h2);
    wait_tick();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (one_hz_tick !== 1'b1);
    check(n, 32'd24, "tick period");
    $display("test tick period done");
    roll(cal(6'h3b, 6'h3b, 5'h17, 3'h7, 5'h1c, 4'h2), 14'h2001,
         cal(6'h0, 6'h0, 5'h0, 3'h1, 5'h01, 4'h3), 14'h2001);
    roll(cal(6'h3b, 6'h3b, 5'h17, 3'h3, 5'h1c, 4'h2), 14'h2004,
         cal(6'h0, 6'h0, 5'h0, 3'h4, 5'h1d, 4'h2), 14'h2004);
    roll(cal(6'h3b, 6'h3b, 5'h17, 3'h4, 5'h1e, 4'h4), 14'h2001,
         cal(6'h0, 6'h0, 5'h0, 3'h5, 5'h01, 4'h5), 14'h2001);
    roll(cal(6'h3b, 6'h3b, 5'h17, 3'h5, 5'h1f, 4'hc), 14'h2099,
         cal(6'h0, 6'h0, 5'h0, 3'h6, 5'h01, 4'h1), 14'h2100);
    $display("test calendar roll done");
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h0, 5'h00, 4'h0), 14'h2001, 1'b1, 1'b1, base);
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h2, 5'h00, 4'h0), 14'h2001, 1'b1, 1'b0, base);
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h1, 5'h01, 4'h3), 14'h0, 1'b1, 1'b1,
               base);
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h0, 5'h02, 4'h0), 14'h2001, 1'b1, 1'b0, base);
    alarm_case(cal(6'h0, 6'h0, 5'h0, 3'h0, 5'h00, 4'hd), 14'h2001, 1'b1, 1'b0,
               cal(6'h0, 6'h0, 5'h0, 3'h1, 5'h01, 4'hd));
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h0, 5'h00, 4'h0), 14'h2002, 1'b1, 1'b0, base);
    alarm_case(cal(6'h3c, 6'h0, 5'h0, 3'h0, 5'h00, 4'h0), 14'h0, 1'b1, 1'b0,
               cal(6'h3c, 6'h0, 5'h0, 3'h1, 5'h01, 4'h3));
    alarm_case(cal(6'h0, 6'h3c, 5'h0, 3'h0, 5'h00, 4'h0), 14'h0, 1'b1, 1'b0,
               cal(6'h0, 6'h3c, 5'h0, 3'h1, 5'h01, 4'h3));
    alarm_case(cal(6'h0, 6'h0, 5'h18, 3'h0, 5'h00, 4'h0), 14'h0, 1'b1, 1'b0,
               cal(6'h0, 6'h0, 5'h18, 3'h1, 5'h01, 4'h3));
    alarm_case(cal(6'h1, 6'h0, 5'h0, 3'h0, 5'h00, 4'h0), 14'h2001, 1'b0, 1'b1, base);
    wr(OFS_IRQ_CLEAR, 32'h1);
    rd(OFS_IRQ_RAW, 32'h0);
    $display("test alarm done");
    results();
  end
endmodule : tb
`default_nettype wire
